/* hw/ppr_receiver.sv */
`timescale 1ns/1ps
// ==========================================
// Printer parallel port receiver, device side
module ppr_receiver
  import ppr_pkg::*;
#(
  parameter int ACK_LEN = ACK_CYCLES,
  parameter int INIT_LEN = INIT_CYCLES,
  parameter int CHAR_LEN = CHAR_CYCLES
)(
  input wire logic clk,
  input wire logic reset,
  input ppr_host_s hostPins,
  output ppr_dev_s devPins,
  output logic autoAdvanceReq,
  output logic irq,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ==========================================
  // Pin synchronisation
  localparam logic [11:0] PIN_IDLE = 12'h0F00; // Controls idle high
  logic [11:0] pinsSync;
  logic [7:0] dataIn;
  logic strobeN;
  logic initN;
  logic autoN;
  logic entryN;

  ppr_sync #(.W(12), .INIT(PIN_IDLE)) uSync (
    .clk(clk),
    .reset(reset),
    .pinIn({hostPins.entryEnableN, hostPins.autoLineAdvanceN, hostPins.initN,
            hostPins.strobeN, hostPins.data}),
    .pinOut(pinsSync)
  );
  // bit one of char on data[0]
  assign dataIn = pinsSync[7:0];
  assign strobeN = pinsSync[8];
  assign initN = pinsSync[9];
  assign autoN = pinsSync[10];
  assign entryN = pinsSync[11];

  // ==========================================
  // Registers
  logic [5:0] ctrl_ff; // Online, paper, error, printing, switches
  logic [7:0] rxData_ff; // Last captured byte
  logic rxFull_ff; // Byte waiting for software
  logic [IRQ_W-1:0] irqStat_ff;
  logic [IRQ_W-1:0] irqMask_ff;
  logic wrStb;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic rdStb;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic wrErr;

  ppr_axil uBus (
    .clk(clk),
    .reset(reset),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdStb(rdStb),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  // Decode helper used for reads and writes
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_DATA) ||
               (a == REG_IRQ_STAT) || (a == REG_IRQ_MASK);
  endfunction
  assign wrErr = !isMapped(wrAddr);
  assign rdErr = !isMapped(rdAddr);

  // ==========================================
  // Derived printer conditions
  logic online;
  logic paperOut;
  logic errorCond;
  logic printing;
  logic entryEnabled;
  logic autoActive;
  logic initLong;
  assign online = ctrl_ff[CTRL_ONLINE];
  assign paperOut = ctrl_ff[CTRL_PAPER_OUT];
  assign errorCond = ctrl_ff[CTRL_ERROR];
  assign printing = ctrl_ff[CTRL_PRINTING];
  assign entryEnabled = ctrl_ff[CTRL_SW18] || !entryN;
  assign autoActive = ctrl_ff[CTRL_SW23] || !autoN;

  // ==========================================
  // Init pulse timer, only a long low counts
  logic [$clog2(INIT_LEN+1)-1:0] initCnt_ff;
  always_ff @(posedge clk)
  begin
    if (reset || initN)
      initCnt_ff <= '0;
    else if (initCnt_ff != INIT_LEN[$clog2(INIT_LEN+1)-1:0])
      initCnt_ff <= initCnt_ff + 1'b1;
  end
  // Reset must wait for the qualified width, glitches ignored
  assign initLong = (initCnt_ff == INIT_LEN[$clog2(INIT_LEN+1)-1:0]);

  // ==========================================
  // Handshake state machine
  ppr_state_e state_ff;
  logic strobeN_d_ff; // Previous strobe for edge detect
  logic strobeFall;
  logic [$clog2(ACK_LEN+1)-1:0] ackCnt_ff;
  logic [$clog2(CHAR_LEN+1)-1:0] paceCnt_ff;
  logic busyOut;
  logic ackOut;
  logic takeByte;
  logic canReceive;

  always_ff @(posedge clk)
  begin
    if (reset)
      strobeN_d_ff <= 1'b1;
    else
      strobeN_d_ff <= strobeN;
  end
  assign strobeFall = strobeN_d_ff && !strobeN;
  // offline, error or printing block entry
  assign canReceive = online && !errorCond && !paperOut && !printing && !rxFull_ff;
  assign takeByte = (state_ff == S_IDLE) && strobeFall && entryEnabled && canReceive;

  // Transfer sequence
  always_ff @(posedge clk)
  begin
    if (reset || initLong)
    begin
      state_ff <= S_IDLE;
      ackCnt_ff <= '0;
      paceCnt_ff <= '0;
    end
    else
    begin
      if (paceCnt_ff != '0)
        paceCnt_ff <= paceCnt_ff - 1'b1;
      case (state_ff)
        S_IDLE:
        begin
          if (takeByte)
          begin
            state_ff <= S_HOLD;
            paceCnt_ff <= CHAR_LEN[$clog2(CHAR_LEN+1)-1:0];
          end
        end
        S_HOLD:
        begin
          if (strobeN)
            state_ff <= S_WAIT;
        end
        S_WAIT:
        begin
          if (paceCnt_ff <= 1 && !printing)
          begin
            state_ff <= S_ACK;
            ackCnt_ff <= ACK_LEN[$clog2(ACK_LEN+1)-1:0];
          end
        end
        S_ACK:
        begin
          if (ackCnt_ff <= 1)
            state_ff <= S_IDLE;
          ackCnt_ff <= ackCnt_ff - 1'b1;
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

  // Data capture while strobe low
  always_ff @(posedge clk)
  begin
    if (reset)
      rxData_ff <= 8'h00;
    else if (takeByte || (state_ff == S_HOLD && !strobeN))
      rxData_ff <= dataIn;
  end

  // Buffer flag: set by strobe wins over software read
  always_ff @(posedge clk)
  begin
    if (reset)
      rxFull_ff <= 1'b0;
    else if (takeByte)
      rxFull_ff <= 1'b1;
    else if (initLong || (rdStb && rdAddr == REG_DATA))
      rxFull_ff <= 1'b0;
  end

  // busy through the acknowledge and until the byte is read, ack after processing
  assign busyOut = (state_ff != S_IDLE) || !canReceive;
  assign ackOut = (state_ff == S_ACK);

  // ==========================================
  // Control register
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_ff <= CTRL_RESET;
    else if (wrStb && wrAddr == REG_CTRL && wrStrb[0])
      ctrl_ff <= wrData[5:0];
  end

  // Interrupt mask
  always_ff @(posedge clk)
  begin
    if (reset)
      irqMask_ff <= '0;
    else if (wrStb && wrAddr == REG_IRQ_MASK && wrStrb[0])
      irqMask_ff <= wrData[IRQ_W-1:0];
  end

  // Sticky events; set wins over clear on read
  logic [IRQ_W-1:0] events;
  logic initLong_d_ff;
  always_ff @(posedge clk)
  begin
    if (reset)
      initLong_d_ff <= 1'b0;
    else
      initLong_d_ff <= initLong;
  end
  always_comb
  begin
    events = '0;
    events[IRQ_BYTE] = takeByte;
    events[IRQ_INIT] = initLong && !initLong_d_ff;
    events[IRQ_OVERRUN] = (state_ff == S_IDLE) && strobeFall && !takeByte;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      irqStat_ff <= '0;
    else if (rdStb && rdAddr == REG_IRQ_STAT)
      irqStat_ff <= events;
    else
      irqStat_ff <= irqStat_ff | events;
  end
  assign irq = |(irqStat_ff & irqMask_ff);

  // ==========================================
  // Read mux
  always_comb
  begin
    rdData = 32'h0000_0000;
    case (rdAddr)
      REG_CTRL: rdData[5:0] = ctrl_ff;
      REG_STATUS: rdData[7:0] = {1'b0, autoActive, entryEnabled, rxFull_ff,
                                 ackOut, busyOut, paperOut, online};
      REG_DATA: rdData[7:0] = rxData_ff;
      REG_IRQ_STAT: rdData[IRQ_W-1:0] = irqStat_ff;
      REG_IRQ_MASK: rdData[IRQ_W-1:0] = irqMask_ff;
      default: rdData = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // Output pins, registered
  ppr_dev_s dev_ff;
  logic autoReq_ff;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dev_ff <= '{byteTakenPulseN: 1'b1, busy: 1'b1, paperEmpty: 1'b0,
                  selectedStatus: 1'b0, faultN: 1'b1};
      autoReq_ff <= 1'b0;
    end
    else
    begin
      dev_ff.byteTakenPulseN <= !ackOut;
      dev_ff.busy <= busyOut;
      dev_ff.paperEmpty <= paperOut;
      dev_ff.selectedStatus <= online;
      // fault low on paper, offline, error
      dev_ff.faultN <= !(paperOut || !online || errorCond);
      // line advance request while printing
      autoReq_ff <= autoActive && printing;
    end
  end
  assign devPins = dev_ff;
  assign autoAdvanceReq = autoReq_ff;
endmodule

/* pkg/ppr_pkg.sv */
// What this block does
// - Accept bytes up to 1000 per second
// - Capture data while strobe is low
// - Eight data bits, high means one
// - Acknowledge low pulse about 5us
// - Busy high when unable to receive
// - Paper empty high when out of paper
// - Selected status while selected
// - Auto line feed when input low
// - Switch 2-3 forces auto feed low
// - Init low resets controller, clears buffer
// - Fault low on paper end, offline, error
// - Accept data only when entry enable low
// - Switch 1-8 forces entry enable low
package ppr_pkg;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int ACK_TIME_NS = 5000;
  localparam int ACK_CYCLES = (ACK_TIME_NS * CLK_MHZ) / 1000;
  localparam int STROBE_MIN_NS = 500;
  localparam int STROBE_CYCLES = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_MIN_NS = 50000;
  localparam int INIT_CYCLES = (INIT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CHAR_PERIOD_NS = 1000000;
  localparam int CHAR_CYCLES = (CHAR_PERIOD_NS / 1000) * CLK_MHZ;
  // ==========================================
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  // Control bit positions
  localparam int CTRL_ONLINE = 0;
  localparam int CTRL_PAPER_OUT = 1;
  localparam int CTRL_ERROR = 2;
  localparam int CTRL_PRINTING = 3;
  localparam int CTRL_SW18 = 4;
  localparam int CTRL_SW23 = 5;
  localparam logic [5:0] CTRL_RESET = 6'h11;
  // Interrupt bits
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_INIT = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int IRQ_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] data;
    logic strobeN;
    logic initN;
    logic autoLineAdvanceN;
    logic entryEnableN;
  } ppr_host_s;

  typedef struct packed {
    logic byteTakenPulseN;
    logic busy;
    logic paperEmpty;
    logic selectedStatus;
    logic faultN;
  } ppr_dev_s;

  typedef enum logic [1:0] {S_IDLE, S_HOLD, S_WAIT, S_ACK} ppr_state_e;
endpackage

/* hw/ppr_sync.sv */
`timescale 1ns/1ps
// ==========================================
// Three flop pin synchroniser with agreement filter
module ppr_sync
  import ppr_pkg::*;
#(
  parameter int W = 12,
  parameter logic [11:0] INIT = 12'h0F00
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] s1_ff; // Metastable stage, read by s2 only
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;

  // Shift chain
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_ff <= INIT[W-1:0];
      s2_ff <= INIT[W-1:0];
      s3_ff <= INIT[W-1:0];
    end
    else
    begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Per bit: change once stage two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (reset)
          out_ff[i] <= INIT[i];
        else if (s2_ff[i] == s3_ff[i])
          out_ff[i] <= s3_ff[i];
      end
    end
  endgenerate
  assign pinOut = out_ff;
endmodule

/* hw/ppr_axil.sv */
`timescale 1ns/1ps
// ==========================================
// AXI4-Lite slave front end, one write and one read at a time
module ppr_axil
  import ppr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wrStb,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic rdStb,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  logic awHave_ff;
  logic wHave_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;

  // Take each write channel independently, either order
  assign awready = !awHave_ff && !bValid_ff;
  assign wready = !wHave_ff && !bValid_ff;
  assign wrStb = awHave_ff && wHave_ff && !bValid_ff;
  assign wrAddr = awAddr_ff;
  assign wrData = wData_ff;
  assign wrStrb = wStrb_ff;

  // Write capture and response
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      if (wrStb)
      begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bValid_ff && bready)
        bValid_ff <= 1'b0;
    end
  end
  assign bvalid = bValid_ff;
  assign bresp = bResp_ff;

  // Read: accept, answer next cycle
  assign arready = !rValid_ff;
  assign rdStb = arvalid && arready;
  assign rdAddr = araddr;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0000_0000;
      rResp_ff <= RESP_OKAY;
    end
    else if (rdStb)
    begin
      rValid_ff <= 1'b1;
      rData_ff <= rdData;
      rResp_ff <= rdErr ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rValid_ff && rready)
      rValid_ff <= 1'b0;
  end
  assign rvalid = rValid_ff;
  assign rdata = rData_ff;
  assign rresp = rResp_ff;
endmodule

/* testbench/ppr_receiver_chk.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker for the parallel receiver
module ppr_receiver_chk
  import ppr_pkg::*;
#(
  parameter int ACK_LEN = ACK_CYCLES
)(
  input wire logic clk,
  input wire logic reset,
  input wire ppr_host_s hostPins,
  input wire ppr_dev_s devPins,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic bvalid,
  input wire logic bready
);
  // Cycles the acknowledge has been low so far
  logic [15:0] lowCnt_ff;
  // Reset seen one edge late, to keep the release edge out of reach
  logic wasReset_ff;

  // ==========================================
  // Delayed reset: values sampled before the release edge are still unknown
  always_ff @(posedge clk)
  begin
    wasReset_ff <= reset;
  end

  // ==========================================
  // Acknowledge length counter
  always_ff @(posedge clk)
  begin
    if (reset || devPins.byteTakenPulseN)
      lowCnt_ff <= 16'h0;
    else
      lowCnt_ff <= lowCnt_ff + 16'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || wasReset_ff);

  // ==========================================
  // Named steps; two samples give registered outputs one edge of skew
  sequence sAckEnd;
    $rose(devPins.byteTakenPulseN);
  endsequence
  sequence sPaperOut;
    devPins.paperEmpty [*2];
  endsequence
  sequence sOffline;
    !devPins.selectedStatus [*2];
  endsequence

  a_ack_width: assert property (sAckEnd |-> lowCnt_ff == 16'(ACK_LEN))
    else $error("acknowledge pulse has the wrong length");
  a_busy_thru_ack: assert property (!devPins.byteTakenPulseN |-> devPins.busy)
    else $error("busy low during acknowledge");
  a_busy_on_strobe: assert property ($fell(hostPins.strobeN) && !devPins.busy && devPins.faultN
    && hostPins.initN && !hostPins.entryEnableN |-> ##[1:8] devPins.busy)
    else $error("busy did not rise after strobe");
  a_paper_fault: assert property (sPaperOut |-> !devPins.faultN && devPins.busy)
    else $error("paper out without fault and busy");
  a_offline_busy: assert property (sOffline |-> devPins.busy && !devPins.faultN)
    else $error("offline without busy and fault");
  a_ack_after_reset: assert property ($fell(reset) |-> devPins.byteTakenPulseN)
    else $error("acknowledge active after reset");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_once: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  a_write_once: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
endmodule

/* testbench/ppr_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Host adapter model driving the printer pins
module ppr_host_model
  import ppr_pkg::*;
#(
  parameter int STB_LEN = STROBE_CYCLES + 1, // One more: width must exceed the minimum
  parameter int INIT_HOLD = 16
)(
  input wire logic clk,
  output ppr_host_s hostPins,
  input wire ppr_dev_s devPins
);
  // Idle: strobe and init high, entry enabled
  initial hostPins = '{8'h00, 1'b1, 1'b1, 1'b1, 1'b0};

  // One byte; ignoreHs breaks the handshake on purpose
  task automatic send_byte(input logic [7:0] d, input bit ignoreHs, output logic ackSeen);
    int n;
    n = 0;
    // Look at registered pins between edges, where they are settled
    @(negedge clk);
    while (!ignoreHs && devPins.busy && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    hostPins.data <= d;
    @(posedge clk);
    // strobe low over the minimum width
    hostPins.strobeN <= 1'b0;
    repeat (STB_LEN) @(posedge clk);
    hostPins.strobeN <= 1'b1;
    @(posedge clk);
    // Hold over: inverse data so stale capture shows
    hostPins.data <= ~d;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (devPins.byteTakenPulseN && n < 600);
    ackSeen = !devPins.byteTakenPulseN;
  endtask

  // Level inputs for entry enable and auto line advance
  task automatic set_lines(input logic entryN, input logic autoN);
    @(posedge clk);
    hostPins.entryEnableN <= entryN;
    hostPins.autoLineAdvanceN <= autoN;
  endtask

  // init held low past the scaled minimum
  task automatic pulse_init();
    @(posedge clk);
    hostPins.initN <= 1'b0;
    repeat (INIT_HOLD) @(posedge clk);
    hostPins.initN <= 1'b1;
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import ppr_pkg::*;
  logic clk;
  logic reset;
  ppr_host_s hostPins;
  ppr_dev_s devPins;
  logic autoAdvanceReq;
  logic irq;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic ack;
  int nMismatch = 0;
  int nCompared = 0;

  // Short counts keep the run small
  ppr_receiver #(.ACK_LEN(8), .INIT_LEN(8), .CHAR_LEN(4)) i_ppr_receiver (.clk, .reset, .hostPins, .devPins,
    .autoAdvanceReq, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  ppr_host_model i_ppr_host_model (.clk, .hostPins, .devPins);

  // ==========================================
  // Checks and bus tasks
  task automatic compare_val(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Drive on the rising edge; ready and answer are looked at between edges,
  // which gives the values the slave sees at the next rising edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic awTake;
    logic wTake;
    logic bTake;
    logic [1:0] resp;
    bTake = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bTake)
    begin
      @(negedge clk);
      awTake = awvalid && awready;
      wTake = wvalid && wready;
      bTake = bvalid;
      resp = bresp;
      @(posedge clk);
      if (awTake) awvalid <= 1'b0;
      if (wTake) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    compare_val({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask

  // Read, then compare masked data and response
  task automatic read_cmp(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic arTake;
    logic rTake;
    logic [31:0] got;
    logic [1:0] resp;
    rTake = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rTake)
    begin
      @(negedge clk);
      arTake = arvalid && arready;
      rTake = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge clk);
      if (arTake) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    compare_val(got & m, e);
    compare_val({30'h0, resp}, {30'h0, er});
  endtask

  // Let pin synchronisers and registered pins settle, stop between edges
  task automatic settle();
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tallyAndFinish();
    $display("compared %0d mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog well past the expected run length
  initial
  begin
    #300000;
    nMismatch++;
    tallyAndFinish();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    reset = 1'b1;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    read_cmp(REG_CTRL, 32'h3F, 32'h11, RESP_OKAY);
    read_cmp(8'h20, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
    settle();
    compare_val({31'h0, devPins.selectedStatus}, 32'h1);
    axi_write(REG_IRQ_MASK, 32'h7);
    i_ppr_host_model.send_byte(8'hA5, 0, ack);
    compare_val({31'h0, ack}, 32'h1);
    compare_val({30'h0, irq, devPins.busy}, 32'h3);
    // Let the acknowledge end, so the refused strobe meets the idle state
    repeat (16) @(posedge clk);
    i_ppr_host_model.send_byte(8'h3C, 1, ack);
    compare_val({31'h0, ack}, 32'h0);
    read_cmp(REG_DATA, 32'hFF, 32'hA5, RESP_OKAY);
    read_cmp(REG_IRQ_STAT, 32'h7, 32'h5, RESP_OKAY);
    compare_val({31'h0, irq}, 32'h0);
    read_cmp(REG_IRQ_STAT, 32'h7, 32'h0, RESP_OKAY);
    i_ppr_host_model.set_lines(1'b1, 1'b1);
    axi_write(REG_CTRL, 32'h01);
    i_ppr_host_model.send_byte(8'h5A, 1, ack);
    compare_val({31'h0, ack}, 32'h0);
    read_cmp(REG_STATUS, 32'h10, 32'h0, RESP_OKAY);
    axi_write(REG_CTRL, 32'h11);
    i_ppr_host_model.send_byte(8'h96, 0, ack);
    compare_val({31'h0, ack}, 32'h1);
    read_cmp(REG_DATA, 32'hFF, 32'h96, RESP_OKAY);
    i_ppr_host_model.set_lines(1'b0, 1'b0);
    axi_write(REG_CTRL, 32'h19);
    settle();
    compare_val({31'h0, autoAdvanceReq}, 32'h1);
    i_ppr_host_model.set_lines(1'b0, 1'b1);
    settle();
    compare_val({31'h0, autoAdvanceReq}, 32'h0);
    axi_write(REG_CTRL, 32'h39);
    settle();
    compare_val({31'h0, autoAdvanceReq}, 32'h1);
    axi_write(REG_CTRL, 32'h10);
    settle();
    compare_val({31'h0, devPins.selectedStatus}, 32'h0);
    compare_val({30'h0, devPins.faultN, devPins.busy}, 32'h1);
    axi_write(REG_CTRL, 32'h15);
    settle();
    compare_val({30'h0, devPins.faultN, devPins.busy}, 32'h1);
    axi_write(REG_CTRL, 32'h13);
    settle();
    compare_val({31'h0, devPins.paperEmpty}, 32'h1);
    compare_val({31'h0, devPins.faultN}, 32'h0);
    axi_write(REG_CTRL, 32'h11);
    i_ppr_host_model.send_byte(8'hC3, 0, ack);
    axi_write(REG_IRQ_MASK, 32'h2);
    read_cmp(REG_IRQ_STAT, 32'h7, 32'h5, RESP_OKAY);
    i_ppr_host_model.pulse_init();
    settle();
    compare_val({31'h0, irq}, 32'h1);
    read_cmp(REG_STATUS, 32'h10, 32'h0, RESP_OKAY);
    read_cmp(REG_IRQ_STAT, 32'h2, 32'h2, RESP_OKAY);
    tallyAndFinish();
  end
endmodule

bind ppr_receiver ppr_receiver_chk #(.ACK_LEN(ACK_LEN)) i_ppr_receiver_chk (.clk, .reset, .hostPins, .devPins,
  .arvalid, .arready, .rvalid, .rready, .bvalid, .bready);
